// ==== design/asc_pkg.sv ====
// Constants, state encoding and access-length lookup for the serial command port.
// Assumes a single 100 MHz system clock domain; serial pins are sampled as synchronous inputs.
package asc_pkg;

   // ----------------------------------------------------------------------
   // Command byte layout
   // ----------------------------------------------------------------------
   localparam int          CMD_W          = 8;
   localparam int          CMD_GATE_BIT   = 7;
   localparam int          CMD_READ_BIT   = 6;
   localparam int          CMD_SEL_HI     = 5;
   localparam int          CMD_SEL_LO     = 3;
   localparam int          CMD_CONT_BIT   = 2;
   localparam logic [7:0]  CMD_RESET      = 8'h00;
   localparam logic [7:0]  CMD_CONT_ENTER = 8'h5c;
   localparam logic [7:0]  CMD_CONT_EXIT  = 8'h58;
   localparam logic [2:0]  CMD_LAST_BIT   = 3'h7;

   // ----------------------------------------------------------------------
   // Register select codes and access widths
   // ----------------------------------------------------------------------
   localparam int          SEL_W          = 3;
   localparam logic [2:0]  SEL_CMD_STATUS = 3'h0;
   localparam logic [2:0]  SEL_MODE       = 3'h1;
   localparam logic [2:0]  SEL_CONFIG     = 3'h2;
   localparam logic [2:0]  SEL_RESULT     = 3'h3;
   localparam logic [2:0]  SEL_IDENT      = 3'h4;
   localparam logic [2:0]  SEL_IO         = 3'h5;
   localparam logic [2:0]  SEL_OFFSET     = 3'h6;
   localparam logic [2:0]  SEL_FULLSCALE  = 3'h7;
   localparam int          DATA_W         = 24;
   localparam logic [4:0]  LEN_8          = 5'h08;
   localparam logic [4:0]  LEN_16         = 5'h10;
   localparam logic [4:0]  LEN_24         = 5'h18;
   localparam logic [4:0]  LEN_ONE        = 5'h01;
   localparam logic [2:0]  BYTE_LAST_BIT  = 3'h7;

   // ----------------------------------------------------------------------
   // Recovery sequence and buffering
   // ----------------------------------------------------------------------
   localparam logic [5:0]  ONES_RESET     = 6'h20;
   localparam int          WFIFO_W        = SEL_W + CMD_W;
   localparam int          WFIFO_DEPTH    = 16;

   typedef enum logic [3:0] {
      ASC_IDLE  = 4'h1,
      ASC_WRITE = 4'h2,
      ASC_READ  = 4'h4,
      ASC_CONT  = 4'h8
   } asc_state_t;

   function automatic logic [4:0] asc_access_len(input logic [2:0] sel);
      logic [4:0] len;
      len = LEN_8;
      case (sel)
         SEL_MODE, SEL_CONFIG:                   len = LEN_16;
         SEL_RESULT, SEL_OFFSET, SEL_FULLSCALE:  len = LEN_24;
         default:                                len = LEN_8;
      endcase
      return len;
   endfunction

endpackage

// ==== design/asc_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact, and a push into a full FIFO is refused.
`timescale 1ns/10ps
`default_nettype none
module asc_fifo #(
   parameter int W     = 11,
   parameter int DEPTH = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wr_ptr;
      logic [AW:0]             rd_ptr;
   } asc_fifo_t;

   asc_fifo_t q;
   asc_fifo_t next_q;
   logic      full;
   logic      empty;

   assign empty     = (q.wr_ptr == q.rd_ptr);
   assign full      = (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]) && (q.wr_ptr[AW] != q.rd_ptr[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = q.mem[q.rd_ptr[AW-1:0]];

   always_comb
   begin
      next_q = q;
      if (in_valid && !full)
      begin
         next_q.mem[q.wr_ptr[AW-1:0]] = in_data;
         next_q.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (out_ready && !empty)
      begin
         next_q.rd_ptr = q.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end
endmodule
`default_nettype wire

// ==== design/asc_serial_cmd.sv ====
// Command decoder of a converter's three-wire serial port (serial clock, data in, data out).
// Assumes serial pins are synchronous to clk_sys, sampled at well over twice the serial clock rate,
// and that the register side holds rd_data valid in the cycle before rd_req is high, as it is captured on the edge that raises rd_req.
`timescale 1ns/10ps
`default_nettype none
module asc_serial_cmd
   import asc_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              sclk,
   input  wire logic              din,
   output logic                   dout,
   input  wire logic              conv_done_n,
   output logic [SEL_W-1:0]       reg_select,
   output logic                   reg_read,
   output logic                   continuous_result_bit,
   output logic                   rd_req,
   input  wire logic [DATA_W-1:0] rd_data,
   output logic                   wr_valid,
   input  wire logic              wr_ready,
   output logic [SEL_W-1:0]       wr_sel,
   output logic [CMD_W-1:0]       wr_data,
   output logic                   wr_lost,
   output logic                   part_reset,
   output logic                   port_idle
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      asc_state_t          st;
      logic                sclk_d;
      logic [CMD_W-1:0]    command_byte;
      logic [CMD_W-2:0]    cmd_sh;
      logic [2:0]          cmd_cnt;
      logic [5:0]          ones;
      logic [4:0]          bit_cnt;
      logic [4:0]          bit_len;
      logic [DATA_W-1:0]   shreg;
      logic [CMD_W-1:0]    wbyte;
      logic [2:0]          wbit;
      logic                dout;
      logic                rd_req;
      logic                part_reset;
      logic                wr_lost;
      logic                streamed;
      logic                streaming;
   } asc_cmd_t;

   asc_cmd_t          q;
   asc_cmd_t          next_q;
   logic              rise;
   logic              fall;
   logic              push;
   logic              push_ready;
   logic [CMD_W-1:0]  full_cmd;
   logic [WFIFO_W-1:0] push_data;
   logic [WFIFO_W-1:0] pop_data;

   assign rise      = sclk && !q.sclk_d;
   assign fall      = !sclk && q.sclk_d;
   assign full_cmd  = {q.cmd_sh, din};

   // ----------------------------------------------------------------------
   // Write data buffer toward the register file
   // ----------------------------------------------------------------------
   // The host cannot be stalled mid-frame, so back-pressure shows as wr_lost.
   asc_fifo #(
      .W     (WFIFO_W),
      .DEPTH (WFIFO_DEPTH)
   ) u_wfifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (pop_data)
   );

   assign wr_sel  = pop_data[WFIFO_W-1:CMD_W];
   assign wr_data = pop_data[CMD_W-1:0];

   always_comb
   begin
      push      = 1'b0;
      push_data = {q.command_byte[CMD_SEL_HI:CMD_SEL_LO], q.wbyte[CMD_W-2:0], din};
      if (q.st == ASC_WRITE && rise && q.wbit == BYTE_LAST_BIT)
      begin
         push = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_q            = q;
      next_q.sclk_d     = sclk;
      next_q.rd_req     = 1'b0;
      next_q.part_reset = 1'b0;

      // Command shifter, live in idle and in continuous reading.
      if (rise && (q.st == ASC_IDLE || q.st == ASC_CONT))
      begin
         if (q.cmd_cnt == 3'h0)
         begin
            if (!din)
            begin
               next_q.cmd_cnt = 3'h1;
               next_q.cmd_sh  = '0;
            end
         end
         else if (q.cmd_cnt == CMD_LAST_BIT)
         begin
            next_q.cmd_cnt = 3'h0;
            if (q.st == ASC_CONT)
            begin
               if (full_cmd == CMD_CONT_EXIT && !conv_done_n)
               begin
                  next_q.command_byte = full_cmd;
                  next_q.st           = ASC_IDLE;
               end
            end
            else
            begin
               next_q.command_byte = full_cmd;
               next_q.bit_cnt      = '0;
               next_q.bit_len      = asc_access_len(full_cmd[CMD_SEL_HI:CMD_SEL_LO]);
               next_q.wbit         = '0;
               if (full_cmd[CMD_READ_BIT])
               begin
                  if (full_cmd[CMD_SEL_HI:CMD_SEL_LO] == SEL_RESULT && full_cmd[CMD_CONT_BIT])
                  begin
                     next_q.st        = ASC_CONT;
                     next_q.streamed  = 1'b0;
                     next_q.streaming = 1'b0;
                  end
                  else
                  begin
                     next_q.st     = ASC_READ;
                     next_q.rd_req = 1'b1;
                     next_q.shreg  = rd_data << (LEN_24 - next_q.bit_len);
                  end
               end
               else if (full_cmd[CMD_SEL_HI:CMD_SEL_LO] != SEL_CMD_STATUS)
               begin
                  next_q.st      = ASC_WRITE;
                  next_q.wr_lost = 1'b0;
               end
            end
         end
         else
         begin
            next_q.cmd_sh  = {q.cmd_sh[CMD_W-3:0], din};
            next_q.cmd_cnt = q.cmd_cnt + 3'h1;
         end
      end

      case (q.st)
         ASC_WRITE:
         begin
            if (rise)
            begin
               next_q.wbyte   = {q.wbyte[CMD_W-2:0], din};
               next_q.wbit    = q.wbit + 3'h1;
               next_q.bit_cnt = q.bit_cnt + LEN_ONE;
               if (push && !push_ready)
               begin
                  next_q.wr_lost = 1'b1;
               end
               if (q.bit_cnt == q.bit_len - LEN_ONE)
               begin
                  next_q.st = ASC_IDLE;
               end
            end
         end
         ASC_READ:
         begin
            if (fall)
            begin
               next_q.dout  = q.shreg[DATA_W-1];
               next_q.shreg = {q.shreg[DATA_W-2:0], 1'b0};
            end
            if (rise)
            begin
               next_q.bit_cnt = q.bit_cnt + LEN_ONE;
               if (q.bit_cnt == q.bit_len - LEN_ONE)
               begin
                  next_q.st = ASC_IDLE;
               end
            end
         end
         ASC_CONT:
         begin
            // A new result is fetched once per low phase of conversion-done.
            if (conv_done_n)
            begin
               next_q.streamed = 1'b0;
            end
            else if (!q.streamed && !q.streaming)
            begin
               next_q.rd_req    = 1'b1;
               next_q.shreg     = rd_data;
               next_q.streamed  = 1'b1;
               next_q.streaming = 1'b1;
               next_q.bit_cnt   = '0;
            end
            if (q.streaming && fall)
            begin
               next_q.dout  = q.shreg[DATA_W-1];
               next_q.shreg = {q.shreg[DATA_W-2:0], 1'b0};
            end
            if (q.streaming && rise)
            begin
               next_q.bit_cnt = q.bit_cnt + LEN_ONE;
               if (q.bit_cnt == LEN_24 - LEN_ONE)
               begin
                  next_q.streaming = 1'b0;
               end
            end
         end
         default:
         begin
            next_q.dout = 1'b0;
         end
      endcase

      // Recovery: consecutive ones on the data input, counted in every state.
      if (rise)
      begin
         if (!din)
         begin
            next_q.ones = '0;
         end
         else if (q.ones == ONES_RESET - 6'h01)
         begin
            next_q            = '0;
            next_q.st         = ASC_IDLE;
            next_q.sclk_d     = sclk;
            next_q.part_reset = 1'b1;
         end
         else
         begin
            next_q.ones = q.ones + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q        <= '0;
         q.st     <= ASC_IDLE;
         q.sclk_d <= 1'b0;
      end
      else
      begin
         q <= next_q;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign dout                  = q.dout;
   assign reg_select            = q.command_byte[CMD_SEL_HI:CMD_SEL_LO];
   assign reg_read              = q.command_byte[CMD_READ_BIT];
   assign continuous_result_bit = q.command_byte[CMD_CONT_BIT];
   assign rd_req                = q.rd_req;
   assign wr_lost               = q.wr_lost;
   assign part_reset            = q.part_reset;
   assign port_idle             = (q.st == ASC_IDLE);

endmodule
`default_nettype wire

// ==== test/asc_serial_cmd_monitor.sv ====
// Assertion checker for the serial command port, bound to the top module's ports.
// Assumes an sclk edge is found by comparing sclk with its previous clk_sys sample.
`timescale 1ns/10ps
`default_nettype none
module asc_monitor
   import asc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             sclk,
   input  wire logic             din,
   input  wire logic             conv_done_n,
   input  wire logic [SEL_W-1:0] reg_select,
   input  wire logic             reg_read,
   input  wire logic             continuous_result_bit,
   input  wire logic             rd_req,
   input  wire logic             wr_valid,
   input  wire logic             wr_ready,
   input  wire logic             part_reset,
   input  wire logic             port_idle
);
   logic       sclk_q;
   logic [4:0] ones;
   wire        rise = sclk & ~sclk_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------------
   // The count wraps to zero on the 32nd one, as the recovery restarts it.
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
      begin
         sclk_q <= 1'b0;
         ones   <= 5'h00;
      end
      else
      begin
         sclk_q <= sclk;
         if (rise)
            ones <= din ? ones + 5'h01 : 5'h00;
      end

   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   property p_reset_idle;
      $rose(rst_n) |-> port_idle && !rd_req;
   endproperty
   property p_lead_one;
      port_idle && rise && din |=> port_idle;
   endproperty
   property p_ones;
      rise && din && ones == 5'h1f |=> part_reset;
   endproperty
   property p_reset_clear;
      part_reset |-> ##[0:1] (port_idle && reg_select == SEL_CMD_STATUS && !continuous_result_bit);
   endproperty
   property p_rd_is_read;
      rd_req |-> reg_read && !port_idle;
   endproperty
   property p_sel_stable;
      !port_idle && !$past(port_idle) |-> $stable(reg_select) && $stable(reg_read);
   endproperty
   property p_read_done;
      rd_req && !continuous_result_bit |-> ##[1:600] port_idle;
   endproperty
   property p_cont_fetch;
      continuous_result_bit && reg_read && reg_select == SEL_RESULT && !port_idle && $fell(conv_done_n) |=> rd_req;
   endproperty

   a_reset_idle: assert property (p_reset_idle)
      else $error("port not idle after reset");
   a_lead_one: assert property (p_lead_one)
      else $error("leading one left idle");
   a_ones: assert property (p_ones)
      else $error("no part reset after 32 ones");
   a_reset_clear: assert property (p_reset_clear)
      else $error("command not cleared by part reset");
   a_rd_is_read: assert property (p_rd_is_read)
      else $error("fetch without read command");
   a_sel_stable: assert property (p_sel_stable)
      else $error("select changed during access");
   a_read_done: assert property (p_read_done)
      else $error("read did not return to idle");
   a_cont_fetch: assert property (p_cont_fetch)
      else $error("no fetch in continuous reading");

   c_read: cover property (rd_req && !continuous_result_bit);
   c_cont: cover property (rd_req && continuous_result_bit);
   c_reset: cover property (part_reset);
   c_pop: cover property (wr_valid && wr_ready);
endmodule
`default_nettype wire

// ==== test/asc_host.sv ====
// Host model of the three-wire link: drives sclk and din, samples dout.
// Assumes one task call at a time; sclk rests high between frames.
`timescale 1ns/10ps
`default_nettype none
module asc_host
(
   input  wire logic clk_sys,
   output logic      sclk,
   output logic      din,
   input  wire logic dout
);
   int half = 3;

   initial
   begin
      sclk = 1'b0;
      din  = 1'b1;
   end

   // Dout is taken half a clk_sys cycle before the rise, half - 0.5 clk_sys cycles after the fall has updated it.
   task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
      rx = 24'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge clk_sys);
         sclk <= 1'b0;
         din  <= tx[i];
         repeat (half) @(posedge clk_sys);
         @(negedge clk_sys);
         rx[i] = dout;
         @(posedge clk_sys);
         sclk <= 1'b1;
         repeat (half) @(posedge clk_sys);
      end
      // Data rests low between frames, as continuous reading asks of the host.
      din <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the serial command port with a host model and random register data.
// Assumes the register side answers rd_data from a value set before each access.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import asc_pkg::*;
   logic              clk_sys = 1'b0, rst_n = 1'b0, conv_done_n = 1'b1, wr_ready = 1'b0;
   logic [DATA_W-1:0] rd_data = 24'h0;
   logic              sclk, din, dout, reg_read, continuous_result_bit, rd_req, wr_valid;
   logic              wr_lost, part_reset, port_idle, drain = 1'b0;
   logic [SEL_W-1:0]  reg_select, wr_sel;
   logic [CMD_W-1:0]  wr_data;
   logic [23:0]       wq[$], rq[$], rx, got;
   integer            seed = 98;
   int                n_errors = 0, n_tests = 0, n_resets = 0;
   event              rd_ev;

   always #5 clk_sys = ~clk_sys;

   asc_host u_host (.clk_sys, .sclk, .din, .dout);
   asc_serial_cmd u_dut (.clk_sys, .rst_n, .sclk, .din, .dout, .conv_done_n, .reg_select, .reg_read,
      .continuous_result_bit, .rd_req, .rd_data, .wr_valid, .wr_ready, .wr_sel, .wr_data, .wr_lost,
      .part_reset, .port_idle);

   task automatic check(input logic [23:0] exp, input logic [23:0] act);
      n_tests++;
      if (act !== exp)
      begin
         n_errors++;
         $display("Error at %0t: expected %h, got %h", $time, exp, act);
      end
   endtask

   task automatic complete_run();
      if (n_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   function automatic int len_of(input logic [2:0] s);
      case (s)
         3'h1, 3'h2:       return 16;
         3'h3, 3'h6, 3'h7: return 24;
         default:          return 8;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Drivers and watchers
   // ----------------------------------------------------------------------
   always @(posedge clk_sys)
      wr_ready <= drain && $random(seed) % 3 != 0;

   // Sampled at the falling edge so the bench never races its own drivers.
   always @(negedge clk_sys)
   begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         check(wq.pop_front(), {13'h0, wr_sel, wr_data});
      if (part_reset === 1'b1)
         n_resets++;
   end

   always @(rd_ev)
      check(rq.pop_front(), got);

   task automatic cmd(input logic [7:0] c);
      u_host.xfer({16'h0, c}, 8, rx);
   endtask

   task automatic do_read(input logic [2:0] s);
      @(posedge clk_sys);
      rd_data <= $random(seed);
      @(posedge clk_sys);
      rq.push_back(rd_data & ((24'h1 << len_of(s)) - 24'h1));
      u_host.xfer(24'hffffff, 3, rx);
      cmd({2'b01, s, 3'b000});
      check({20'h0, 1'b1, s}, {20'h0, reg_read, reg_select});
      u_host.xfer(24'h0, len_of(s), got);
      -> rd_ev;
      check(24'h1, {23'h0, port_idle});
   endtask

   task automatic do_write(input logic [2:0] s);
      logic [23:0] v;
      v = $random(seed);
      cmd({2'b00, s, 3'b000});
      check({20'h0, 1'b0, s}, {20'h0, reg_read, reg_select});
      for (int b = len_of(s) / 8 - 1; b >= 0; b--)
         if (wq.size() < WFIFO_DEPTH)
            wq.push_back({13'h0, s, v[b*8 +: 8]});
      u_host.xfer(v, len_of(s), rx);
      check(24'h1, {23'h0, port_idle});
   endtask

   task automatic wait_empty();
      for (int i = 0; i < 400 && wr_valid !== 1'b0; i++)
         @(posedge clk_sys);
      check(24'h0, {23'h0, wr_valid});
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      check(24'h1, {23'h0, port_idle});
      drain <= 1'b1;
      for (int s = 0; s < 8; s++)
      begin
         u_host.half = 3 + s % 3;
         do_read(s[2:0]);
         if (s != 0)
            do_write(s[2:0]);
      end
      cmd(CMD_RESET);
      check(24'h1, {23'h0, port_idle});
      wait_empty();
      drain <= 1'b0;
      repeat (9) do_write(3'h2);
      check(24'h1, {23'h0, wr_lost});
      drain <= 1'b1;
      wait_empty();
      do_write(3'h1);
      check(24'h0, {23'h0, wr_lost});
      cmd(CMD_CONT_ENTER);
      check(24'h1, {23'h0, continuous_result_bit});
      repeat (2)
      begin
         @(posedge clk_sys);
         rd_data     <= $random(seed);
         conv_done_n <= 1'b0;
         @(posedge clk_sys);
         rq.push_back(rd_data);
         u_host.xfer(24'h0, 24, got);
         -> rd_ev;
         conv_done_n <= 1'b1;
      end
      cmd(CMD_CONT_EXIT);
      check(24'h0, {23'h0, port_idle});
      conv_done_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cmd(CMD_CONT_EXIT);
      check(24'h1, {23'h0, port_idle});
      conv_done_n <= 1'b1;
      cmd(8'h50);
      u_host.xfer(24'hffffff, 24, rx);
      u_host.xfer(24'hffffff, 16, rx);
      check(24'h1, n_resets[23:0]);
      check({20'h0, 1'b1, SEL_CMD_STATUS}, {20'h0, port_idle, reg_select});
      complete_run();
   end

   initial
   begin
      #400000;
      n_errors++;
      complete_run();
   end
endmodule

bind asc_serial_cmd asc_monitor u_mon (.clk_sys, .rst_n, .sclk, .din, .conv_done_n, .reg_select,
   .reg_read, .continuous_result_bit, .rd_req, .wr_valid, .wr_ready, .part_reset, .port_idle);
`default_nettype wire
